/* cem_error_flags.sv */
// configuration error cause register with its error detection and host read port
// Functional notes
// RULE_01: register answers at bytes 08h-0Bh, or words 04h-05h in word mode
// RULE_02: bit 0 sets when card reset is not done before its time-out
// RULE_03: bit 1 sets when card is not ready before its time-out
// RULE_04: bit 2 sets when a sector read or identify command fails
// RULE_05: bit 3 sets when a sector write command fails
// RULE_06: bit 4 sets when a sector does not become valid before time-out
// RULE_07: bit 5 sets when the chosen image address is not on the card
// RULE_08: image address comes from register field or pins, per override bit
// RULE_09: bit 6 sets when programming the target chain fails
// RULE_10: bit 7 sets on an error reading configuration data from the card
// RULE_11: bit 8 sets on an invalid instruction in the configuration data
// RULE_12: bit 9 sets if init input stays low 500 ms after configuration starts
// RULE_13: bit 11 mirrors the card's bad block flag
// RULE_14: bit 12 mirrors the card's uncorrectable data flag
// RULE_15: bit 13 mirrors the card's sector id missing flag
// RULE_16: bit 14 mirrors the card's command abort flag
// RULE_17: bit 15 mirrors the card's general error flag
// RULE_18: host reads this register when the status error summary bit is set
// RULE_19: bit 10 and bits 31:16 read zero; host writes change nothing
// RULE_20: mirrored bits refresh on each card read; local bits hold until reset
`timescale 1ns/10ps
`include "cem_defs.svh"
module cem_error_flags #(
    parameter int unsigned INIT_TIMEOUT_CYC   = `CEM_INIT_TIMEOUT_CYC,
    parameter int unsigned RESET_TIMEOUT_CYC  = `CEM_RESET_TIMEOUT_CYC,
    parameter int unsigned READY_TIMEOUT_CYC  = `CEM_READY_TIMEOUT_CYC,
    parameter int unsigned SECTOR_TIMEOUT_CYC = `CEM_SECTOR_TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     reset_n,
    // host port
    input  wire logic                     mpuCs_n,
    input  wire logic                     mpuRd_n,
    input  wire logic                     mpuWr_n,
    input  wire logic                     wordMode,
    input  wire logic [6:0]               mpuAddr,
    input  wire cem_pkg::cem_half_t       mpuDataIn,
    output cem_pkg::cem_half_t            mpuDataOut,
    output logic                          mpuDataOe,
    // card handling progress
    input  wire logic                     cardResetStart,
    input  wire logic                     cardResetDone,
    input  wire logic                     cardReadyWaitStart,
    input  wire logic                     cardReady,
    input  wire logic                     sectorWaitStart,
    input  wire logic                     sectorValid,
    input  wire logic                     sectorReadCmdFail,
    input  wire logic                     identifyCmdFail,
    input  wire logic                     sectorWriteCmdFail,
    // card error register snapshot
    input  wire logic [7:0]               cardErrValue,
    input  wire logic                     cardErrLoad,
    // configuration engine
    input  wire cem_pkg::cem_image_addr_t imageAddressSelect,
    input  wire logic [1:0]               imageAddressPins,
    input  wire logic                     overrideImageAddressPins,
    input  wire cem_pkg::cem_image_addr_t imageCount,
    input  wire logic                     addrCheckStrobe,
    input  wire logic                     chainProgramFail,
    input  wire logic                     imageReadFail,
    input  wire logic                     badInstructionFound,
    input  wire logic                     cfgStart,
    input  wire logic                     targetInitInput,
    // summary
    output logic [31:0]                   errorCauseFlags,
    output logic                          anyError
);
    import cem_pkg::*;

    logic [1:0]  rstPipe_q;
    wire         rstSync_n = rstPipe_q[1];

    // asynchronous assert, clean release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) rstPipe_q <= 2'b00;
        else          rstPipe_q <= {rstPipe_q[0], 1'b1};
    end

    // ---------------- error detectors ----------------
    logic resetExpired;
    logic readyExpired;
    logic sectorExpired;
    logic initExpired;
    logic addrInvalidEvt;

    cem_timeout_mon #(.LIMIT(RESET_TIMEOUT_CYC)) uResetMon (
        .clock       (clock),
        .resetSync_n (rstSync_n),
        .start       (cardResetStart),
        .done        (cardResetDone),
        .expired     (resetExpired)
    ); // [RULE_02]

    cem_timeout_mon #(.LIMIT(READY_TIMEOUT_CYC)) uReadyMon (
        .clock       (clock),
        .resetSync_n (rstSync_n),
        .start       (cardReadyWaitStart),
        .done        (cardReady),
        .expired     (readyExpired)
    ); // [RULE_03]

    cem_timeout_mon #(.LIMIT(SECTOR_TIMEOUT_CYC)) uSectorMon (
        .clock       (clock),
        .resetSync_n (rstSync_n),
        .start       (sectorWaitStart),
        .done        (sectorValid),
        .expired     (sectorExpired)
    ); // [RULE_06]

    cem_timeout_mon #(.LIMIT(INIT_TIMEOUT_CYC)) uInitMon (
        .clock       (clock),
        .resetSync_n (rstSync_n),
        .start       (cfgStart),
        .done        (targetInitInput),
        .expired     (initExpired)
    ); // [RULE_12]

    cem_addr_check uAddrCheck (
        .clock                    (clock),
        .resetSync_n              (rstSync_n),
        .imageAddressSelect       (imageAddressSelect),
        .imageAddressPins         (imageAddressPins),
        .overrideImageAddressPins (overrideImageAddressPins),
        .imageCount               (imageCount),
        .checkStrobe              (addrCheckStrobe),
        .invalidEvt               (addrInvalidEvt)
    ); // [RULE_07] [RULE_08]

    // ---------------- sticky local flags ----------------
    logic [`CEM_LOCAL_COUNT-1:0] localEvt;
    logic [`CEM_LOCAL_COUNT-1:0] localFlag_q;

    assign localEvt[`CEM_B_CARD_RESET]   = resetExpired;                        // [RULE_02]
    assign localEvt[`CEM_B_CARD_READY]   = readyExpired;                        // [RULE_03]
    assign localEvt[`CEM_B_READ_CMD]     = sectorReadCmdFail | identifyCmdFail; // [RULE_04]
    assign localEvt[`CEM_B_WRITE_CMD]    = sectorWriteCmdFail;                  // [RULE_05]
    assign localEvt[`CEM_B_SECTOR_VALID] = sectorExpired;                       // [RULE_06]
    assign localEvt[`CEM_B_IMAGE_ADDR]   = addrInvalidEvt;                      // [RULE_07]
    assign localEvt[`CEM_B_CHAIN_FAIL]   = chainProgramFail;                    // [RULE_09]
    assign localEvt[`CEM_B_IMAGE_READ]   = imageReadFail;                       // [RULE_10]
    assign localEvt[`CEM_B_BAD_INSTR]    = badInstructionFound;                 // [RULE_11]
    assign localEvt[`CEM_B_INIT_TIMEOUT] = initExpired;                         // [RULE_12]

    // no host clear exists, so these only leave the set state through reset
    for (genvar i = 0; i < `CEM_LOCAL_COUNT; i++) begin : gLocal
        always_ff @(posedge clock or negedge rstSync_n) begin
            if (!rstSync_n) localFlag_q[i] <= 1'b0;
            else            localFlag_q[i] <= localFlag_q[i] | localEvt[i]; // [RULE_20]
        end
    end

    // ---------------- card mirror flags ----------------
    logic [4:0] cardMirror_q;
    logic [4:0] cardMirror_d;

    assign cardMirror_d = {cardErrValue[`CEM_CARD_AMNF],   // [RULE_17]
                           cardErrValue[`CEM_CARD_ABRT],   // [RULE_16]
                           cardErrValue[`CEM_CARD_IDNF],   // [RULE_15]
                           cardErrValue[`CEM_CARD_UNC],    // [RULE_14]
                           cardErrValue[`CEM_CARD_BBK]};   // [RULE_13]

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n)       cardMirror_q <= 5'h00;
        else if (cardErrLoad) cardMirror_q <= cardMirror_d; // [RULE_20]
    end

    // ---------------- register image ----------------
    logic [31:0] errWord;

    // reserved bits are tied low; nothing the host drives reaches this word
    assign errWord = {16'h0000, cardMirror_q, 1'b0, localFlag_q}; // [RULE_19]
    assign errorCauseFlags = errWord;
    assign anyError        = |errWord;

    // ---------------- host read port ----------------
    wire        rdActive = !mpuCs_n && !mpuRd_n;
    wire        byteHit  = !wordMode && (mpuAddr >= `CEM_ERR_BYTE_FIRST)
                                     && (mpuAddr <= `CEM_ERR_BYTE_LAST);
    wire        wordHit  =  wordMode && (mpuAddr >= `CEM_ERR_WORD_FIRST)
                                     && (mpuAddr <= `CEM_ERR_WORD_LAST);
    wire        regHit   = byteHit || wordHit;                          // [RULE_01]
    wire [7:0]  byteSel  = errWord[{mpuAddr[1:0], 3'b000} +: 8];
    wire [15:0] halfSel  = errWord[{mpuAddr[0], 4'b0000} +: 16];
    wire [15:0] readMux  = wordMode ? halfSel : {8'h00, byteSel};

    cem_half_t  dataOut_q;

    // one cycle to the answer keeps the pad drive off the flag logic path
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n)                dataOut_q <= 16'h0000;
        else if (rdActive && regHit)   dataOut_q <= readMux; // [RULE_01]
    end

    assign mpuDataOut = dataOut_q;
    assign mpuDataOe  = rdActive && regHit;

    // the write strobe and data are accepted silently: the register is read only
    wire writeIgnored = !mpuCs_n && !mpuWr_n && regHit && (mpuDataIn != 16'hFFFF);

    // ---------------- assertions ----------------
    sequence sReadHit;
        rdActive && regHit;
    endsequence

    sequence sCfgWaitLow;
        cfgStart ##1 (!targetInitInput && !cfgStart) [*2];
    endsequence

    sequence sResetWaitLow;
        cardResetStart ##1 (!cardResetDone && !cardResetStart) [*2];
    endsequence

    a_reset_timeout_flag: assert property ( // [RULE_02]
        @(posedge clock) disable iff (!rstSync_n)
        resetExpired |=> errWord[`CEM_B_CARD_RESET])
        else $error("card reset time-out did not set bit 0");

    a_ready_timeout_flag: assert property ( // [RULE_03]
        @(posedge clock) disable iff (!rstSync_n)
        cardReadyWaitStart ##1 (!cardReady && !cardReadyWaitStart) [*2]
        |-> !errWord[`CEM_B_CARD_READY] || $past(errWord[`CEM_B_CARD_READY], 3))
        else $error("ready flag rose too early");

    a_read_cmd_flag: assert property ( // [RULE_04]
        @(posedge clock) disable iff (!rstSync_n)
        (sectorReadCmdFail || identifyCmdFail) |=> errWord[`CEM_B_READ_CMD])
        else $error("read command failure not flagged");

    a_write_cmd_flag: assert property ( // [RULE_05]
        @(posedge clock) disable iff (!rstSync_n)
        sectorWriteCmdFail |=> errWord[`CEM_B_WRITE_CMD])
        else $error("write command failure not flagged");

    a_sector_timeout_flag: assert property ( // [RULE_06]
        @(posedge clock) disable iff (!rstSync_n)
        sectorExpired |=> errWord[`CEM_B_SECTOR_VALID])
        else $error("sector time-out did not set bit 4");

    a_image_addr_check: assert property ( // [RULE_07] [RULE_08]
        @(posedge clock) disable iff (!rstSync_n)
        (addrCheckStrobe && ((overrideImageAddressPins ? imageAddressSelect
            : {14'h0000, imageAddressPins}) >= imageCount))
        |-> ##2 errWord[`CEM_B_IMAGE_ADDR])
        else $error("invalid image address not flagged in two cycles");

    a_image_addr_source: assert property ( // [RULE_08]
        @(posedge clock) disable iff (!rstSync_n)
        (addrCheckStrobe && !errWord[`CEM_B_IMAGE_ADDR] && !overrideImageAddressPins
            && ({14'h0000, imageAddressPins} < imageCount))
        |=> !addrInvalidEvt)
        else $error("pin address wrongly judged invalid");

    a_chain_fail_flag: assert property ( // [RULE_09]
        @(posedge clock) disable iff (!rstSync_n)
        chainProgramFail |=> errWord[`CEM_B_CHAIN_FAIL])
        else $error("chain failure not flagged");

    a_image_read_flag: assert property ( // [RULE_10]
        @(posedge clock) disable iff (!rstSync_n)
        imageReadFail |=> errWord[`CEM_B_IMAGE_READ])
        else $error("image read error not flagged");

    a_bad_instr_flag: assert property ( // [RULE_11]
        @(posedge clock) disable iff (!rstSync_n)
        badInstructionFound |=> errWord[`CEM_B_BAD_INSTR])
        else $error("bad instruction not flagged");

    a_init_no_early: assert property ( // [RULE_12]
        @(posedge clock) disable iff (!rstSync_n)
        sCfgWaitLow |-> !initExpired)
        else $error("init time-out fired too early");

    a_init_timeout_flag: assert property ( // [RULE_12]
        @(posedge clock) disable iff (!rstSync_n)
        initExpired |=> errWord[`CEM_B_INIT_TIMEOUT])
        else $error("init time-out did not set bit 9");

    a_mirror_bad_block: assert property ( // [RULE_13]
        @(posedge clock) disable iff (!rstSync_n)
        cardErrLoad |=> errWord[`CEM_B_BAD_BLOCK] == $past(cardErrValue[`CEM_CARD_BBK]))
        else $error("bad block mirror wrong");

    a_mirror_uncorr: assert property ( // [RULE_14]
        @(posedge clock) disable iff (!rstSync_n)
        cardErrLoad |=> errWord[`CEM_B_UNCORRECTABLE] == $past(cardErrValue[`CEM_CARD_UNC]))
        else $error("uncorrectable mirror wrong");

    a_mirror_id_missing: assert property ( // [RULE_15]
        @(posedge clock) disable iff (!rstSync_n)
        cardErrLoad |=> errWord[`CEM_B_ID_MISSING] == $past(cardErrValue[`CEM_CARD_IDNF]))
        else $error("id missing mirror wrong");

    a_mirror_abort: assert property ( // [RULE_16]
        @(posedge clock) disable iff (!rstSync_n)
        cardErrLoad |=> errWord[`CEM_B_CMD_ABORT] == $past(cardErrValue[`CEM_CARD_ABRT]))
        else $error("abort mirror wrong");

    a_mirror_general: assert property ( // [RULE_17]
        @(posedge clock) disable iff (!rstSync_n)
        cardErrLoad |=> errWord[`CEM_B_GENERAL] == $past(cardErrValue[`CEM_CARD_AMNF]))
        else $error("general error mirror wrong");

    a_mirror_hold: assert property ( // [RULE_20]
        @(posedge clock) disable iff (!rstSync_n)
        !cardErrLoad |=> $stable(errWord[`CEM_B_GENERAL:`CEM_B_BAD_BLOCK]))
        else $error("mirror bits moved without a card read");

    a_local_sticky: assert property ( // [RULE_20]
        @(posedge clock) disable iff (!rstSync_n)
        errWord[`CEM_B_INIT_TIMEOUT:0] != 10'h000
        |=> (errWord[`CEM_B_INIT_TIMEOUT:0] & $past(errWord[`CEM_B_INIT_TIMEOUT:0]))
            == $past(errWord[`CEM_B_INIT_TIMEOUT:0]))
        else $error("a local error bit dropped before reset");

    a_reserved_bytes: assert property ( // [RULE_19]
        @(posedge clock) disable iff (!rstSync_n)
        (sReadHit and (!wordMode && mpuAddr[1])) |=> mpuDataOut == 16'h0000)
        else $error("upper bytes did not read zero");

    a_write_no_effect: assert property ( // [RULE_19]
        @(posedge clock) disable iff (!rstSync_n)
        (writeIgnored && !cardErrLoad && localEvt == '0) |=> $stable(errWord))
        else $error("host write changed the register");

    a_read_answer: assert property ( // [RULE_01]
        @(posedge clock) disable iff (!rstSync_n)
        sReadHit |=> mpuDataOut == $past(readMux))
        else $error("read answer not delivered next cycle");

    a_decode_window: assert property ( // [RULE_01]
        @(posedge clock) disable iff (!rstSync_n)
        mpuDataOe |-> (wordMode ? (mpuAddr[6:1] == 6'h02) : (mpuAddr[6:2] == 5'h02)))
        else $error("register answered outside its offsets");

    a_oe_needs_strobe: assert property ( // [RULE_01]
        @(posedge clock) disable iff (!rstSync_n)
        mpuDataOe |-> (!mpuCs_n && !mpuRd_n))
        else $error("read drive without a read strobe");

    a_local_no_spurious: assert property ( // [RULE_20]
        @(posedge clock) disable iff (!rstSync_n)
        (localEvt == '0) |=> $stable(errWord[`CEM_B_INIT_TIMEOUT:0]))
        else $error("a local error bit set with no event");

    a_reset_no_early: assert property ( // [RULE_02]
        @(posedge clock) disable iff (!rstSync_n)
        sResetWaitLow |-> !resetExpired)
        else $error("card reset time-out fired too early");
endmodule

/* cem_defs.svh */
// constants for the configuration error cause register
`ifndef CEM_DEFS_SVH
`define CEM_DEFS_SVH

// register placement on the host port
`define CEM_ERR_BYTE_FIRST   7'h08
`define CEM_ERR_BYTE_LAST    7'h0B
`define CEM_ERR_WORD_FIRST   7'h04
`define CEM_ERR_WORD_LAST    7'h05
`define CEM_ERR_RESET        32'h0000_0000

// field positions of error_cause_flags
`define CEM_B_CARD_RESET     0
`define CEM_B_CARD_READY     1
`define CEM_B_READ_CMD       2
`define CEM_B_WRITE_CMD      3
`define CEM_B_SECTOR_VALID   4
`define CEM_B_IMAGE_ADDR     5
`define CEM_B_CHAIN_FAIL     6
`define CEM_B_IMAGE_READ     7
`define CEM_B_BAD_INSTR      8
`define CEM_B_INIT_TIMEOUT   9
`define CEM_B_RESERVED10     10
`define CEM_B_BAD_BLOCK      11
`define CEM_B_UNCORRECTABLE  12
`define CEM_B_ID_MISSING     13
`define CEM_B_CMD_ABORT      14
`define CEM_B_GENERAL        15
`define CEM_LOCAL_COUNT      10

// positions inside the card's own error register
`define CEM_CARD_BBK         7
`define CEM_CARD_UNC         6
`define CEM_CARD_IDNF        4
`define CEM_CARD_ABRT        2
`define CEM_CARD_AMNF        0

// timing
`define CEM_CLK_MHZ          100
`define CEM_INIT_TIMEOUT_MS  500
`define CEM_INIT_TIMEOUT_CYC (`CEM_INIT_TIMEOUT_MS * 1000 * `CEM_CLK_MHZ)
`define CEM_RESET_TIMEOUT_CYC  1000
`define CEM_READY_TIMEOUT_CYC  1000
`define CEM_SECTOR_TIMEOUT_CYC 1000

`endif

/* cem_pkg.sv */
// types shared by the configuration error cause register
package cem_pkg;
    typedef enum logic {CEM_IDLE, CEM_WAIT} cem_mon_state_t;
    typedef logic [15:0] cem_image_addr_t;
    typedef logic [15:0] cem_half_t;
endpackage

/* cem_timeout_mon.sv */
// watches for a condition to arrive within a bounded number of cycles
`timescale 1ns/10ps
module cem_timeout_mon #(
    parameter int unsigned LIMIT = 16
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetSync_n,
    // watch control
    input  wire logic start,
    input  wire logic done,
    // result
    output logic      expired
);
    import cem_pkg::*;
    localparam int unsigned W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    cem_mon_state_t state_q;
    logic [W-1:0]   count_q;
    logic           expired_q;
    wire            atLast = (count_q == LAST);

    // a fresh start restarts the watch even while one is pending
    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) begin
            state_q   <= CEM_IDLE;
            count_q   <= '0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= 1'b0;
            case (state_q)
                CEM_IDLE: begin
                    count_q <= '0;
                    if (start) state_q <= CEM_WAIT;
                end
                CEM_WAIT: begin
                    if (start) begin
                        count_q <= '0;
                    end else if (done) begin
                        state_q <= CEM_IDLE;
                    end else if (atLast) begin
                        expired_q <= 1'b1;
                        state_q   <= CEM_IDLE;
                    end else begin
                        count_q <= count_q + 1'b1;
                    end
                end
                default: state_q <= CEM_IDLE;
            endcase
        end
    end

    assign expired = expired_q;
endmodule

/* cem_addr_check.sv */
// selects the image address source and checks it against the card's image count
`timescale 1ns/10ps
module cem_addr_check (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               resetSync_n,
    // address sources
    input  wire cem_pkg::cem_image_addr_t imageAddressSelect,
    input  wire logic [1:0]         imageAddressPins,
    input  wire logic               overrideImageAddressPins,
    input  wire cem_pkg::cem_image_addr_t imageCount,
    input  wire logic               checkStrobe,
    // result
    output logic                    invalidEvt
);
    import cem_pkg::*;
    cem_image_addr_t chosenAddr;
    logic            invalidEvt_q;

    assign chosenAddr = overrideImageAddressPins ? imageAddressSelect
                                                 : {14'h0000, imageAddressPins};

    always_ff @(posedge clock or negedge resetSync_n) begin
        if (!resetSync_n) invalidEvt_q <= 1'b0;
        else              invalidEvt_q <= checkStrobe && (chosenAddr >= imageCount);
    end

    assign invalidEvt = invalidEvt_q;
endmodule

/* cem_card_model.sv */
// card side model: answers reset, ready and sector waits and supplies its error register
`timescale 1ns/10ps
module cem_card_model (
    // clock
    input  wire logic       clock,
    // requests from the block
    input  wire logic       startAny,
    input  wire logic       slow,
    input  wire logic [7:0] errCode,
    input  wire logic       errGo,
    // card answers
    output logic            ready,
    output logic [7:0]      errValue,
    output logic            errLoad
);
    int count = 0;
    // a slow card never answers while slow is held, so the reset, ready and sector watches can be made to expire
    assign ready = (count == 0) && !slow;
    always @(posedge clock) begin
        if (startAny) begin
            count <= 2;
        end else if (count > 0) begin
            count <= count - 1;
        end
        errLoad <= errGo;
        // released register bus does not hold its last value
        errValue <= errGo ? errCode : ~errValue;
    end
endmodule

/* cem_error_flags_bench.sv */
// self-checking bench for the configuration error cause register
`timescale 1ns/10ps
module cem_error_flags_bench;
    import cem_pkg::*;
    logic            clock = 1'h0, reset_n = 1'h0, mpuCs_n = 1'h1, mpuRd_n = 1'h1;
    logic            mpuWr_n = 1'h1, wordMode = 1'h0, slow = 1'h0, errGo = 1'h0;
    logic            rstGo = 1'h0, rdyGo = 1'h0, secGo = 1'h0, rdFail = 1'h0, idFail = 1'h0;
    logic            wrFail = 1'h0, chain = 1'h0, imgRd = 1'h0, badIns = 1'h0, ovr = 1'h0;
    logic            cfgStart = 1'h0, initIn = 1'h1, strobe = 1'h0;
    logic            mpuDataOe, anyError, rdy, errLoad;
    logic [6:0]      mpuAddr = 7'h00;
    logic [1:0]      pins = 2'h3;
    logic [7:0]      errCode = 8'h00, errValue;
    logic [31:0]     flags, expFlags = 32'h0;
    cem_half_t       mpuDataIn = 16'h5A5A, mpuDataOut;
    cem_image_addr_t sel = 16'h0009, cnt = 16'h0004;
    int              numErrors = 0, checked = 0;

    cem_error_flags #(.INIT_TIMEOUT_CYC(20), .RESET_TIMEOUT_CYC(8), .READY_TIMEOUT_CYC(8),
        .SECTOR_TIMEOUT_CYC(8)) u_cem_error_flags (
        .clock(clock), .reset_n(reset_n), .mpuCs_n(mpuCs_n), .mpuRd_n(mpuRd_n),
        .mpuWr_n(mpuWr_n), .wordMode(wordMode), .mpuAddr(mpuAddr), .mpuDataIn(mpuDataIn),
        .mpuDataOut(mpuDataOut), .mpuDataOe(mpuDataOe), .cardResetStart(rstGo),
        .cardResetDone(rdy), .cardReadyWaitStart(rdyGo), .cardReady(rdy),
        .sectorWaitStart(secGo), .sectorValid(rdy), .sectorReadCmdFail(rdFail),
        .identifyCmdFail(idFail), .sectorWriteCmdFail(wrFail), .cardErrValue(errValue),
        .cardErrLoad(errLoad), .imageAddressSelect(sel), .imageAddressPins(pins),
        .overrideImageAddressPins(ovr), .imageCount(cnt), .addrCheckStrobe(strobe),
        .chainProgramFail(chain), .imageReadFail(imgRd), .badInstructionFound(badIns),
        .cfgStart(cfgStart), .targetInitInput(initIn), .errorCauseFlags(flags),
        .anyError(anyError));
    cem_card_model u_cem_card_model (.clock(clock), .startAny(rstGo | rdyGo | secGo),
        .slow(slow), .errCode(errCode), .errGo(errGo), .ready(rdy), .errValue(errValue),
        .errLoad(errLoad));

    always #5 clock = ~clock;

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            numErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic do_reset();
        reset_n = 1'h0;
        tick(4);
        reset_n = 1'h1;
        tick(4);
        expFlags = 32'h0;
        chk("cleared by reset", flags, 32'h0);
    endtask
    // data is looked at half a cycle after the edge that takes the read
    task automatic rd(logic wm, logic [6:0] a, logic [15:0] exp);
        wordMode = wm;
        mpuAddr = a;
        mpuCs_n = 1'h0;
        mpuRd_n = 1'h0;
        tick(1);
        chk("read enable", mpuDataOe, 32'h1);
        chk("read data", mpuDataOut, exp);
        mpuCs_n = 1'h1;
        mpuRd_n = 1'h1;
        tick(1);
    endtask
    task automatic read_all(logic [31:0] exp);
        rd(1'h0, 7'h08, {8'h00, exp[7:0]});
        rd(1'h0, 7'h09, {8'h00, exp[15:8]});
        rd(1'h0, 7'h0A, 16'h0000);
        rd(1'h0, 7'h0B, 16'h0000);
        rd(1'h1, 7'h04, exp[15:0]);
        rd(1'h1, 7'h05, 16'h0000);
        chk("flags", flags, exp);
        chk("summary", anyError, {31'h0, |exp});
    endtask
    task automatic write_try();
        wordMode = 1'h0;
        mpuAddr = 7'h08;
        mpuCs_n = 1'h0;
        mpuWr_n = 1'h0;
        tick(2);
        mpuWr_n = 1'h1;
        mpuAddr = 7'h0C;
        mpuRd_n = 1'h0;
        tick(1);
        chk("unmapped enable", mpuDataOe, 32'h0);
        mpuCs_n = 1'h1;
        mpuRd_n = 1'h1;
        tick(1);
        chk("after write", flags, 32'h0);
    endtask
    task automatic pulse(ref logic s, input int bitNo, input logic sets);
        s = 1'h1;
        tick(1);
        s = 1'h0;
        tick(3);
        expFlags[bitNo] |= sets;
        chk("event flag", flags, expFlags);
    endtask
    // the init input is driven here in the target's place
    task automatic watch(ref logic s, input logic isSlow, input int bitNo);
        slow = isSlow;
        initIn = !isSlow;
        tick(1);
        s = 1'h1;
        tick(1);
        s = 1'h0;
        tick(24);
        expFlags[bitNo] |= isSlow;
        chk("watch flag", flags, expFlags);
        slow = 1'h0;
        tick(2);
    endtask
    task automatic mirror(logic [7:0] code, logic [4:0] exp);
        errCode = code;
        errGo = 1'h1;
        tick(1);
        errGo = 1'h0;
        tick(3);
        expFlags[15:11] = exp;
        chk("mirror", flags, expFlags);
    endtask

    initial begin
        #50000;
        numErrors++;
        give_verdict();
    end
    initial begin
        do_reset();
        read_all(32'h0);
        write_try();
        pulse(idFail, 2, 1'h1);
        do_reset();
        pulse(rdFail, 2, 1'h1);
        pulse(wrFail, 3, 1'h1);
        pulse(chain, 6, 1'h1);
        pulse(imgRd, 7, 1'h1);
        pulse(badIns, 8, 1'h1);
        pulse(strobe, 5, 1'h0);
        ovr = 1'h1;
        sel = 16'h0003;
        pulse(strobe, 5, 1'h0);
        sel = 16'h0004;
        pulse(strobe, 5, 1'h1);
        watch(rstGo, 1'h0, 0);
        watch(rstGo, 1'h1, 0);
        watch(rdyGo, 1'h0, 1);
        watch(rdyGo, 1'h1, 1);
        watch(secGo, 1'h0, 4);
        watch(secGo, 1'h1, 4);
        watch(cfgStart, 1'h0, 9);
        watch(cfgStart, 1'h1, 9);
        mirror(8'hB9, 5'h15);
        mirror(8'h46, 5'h0A);
        read_all(expFlags);
        give_verdict();
    end
endmodule
